//--- xlcr_lane_config_regs.sv
`timescale 1ns/1ps
`include "xlcr_defines.svh"
module xlcr_lane_config_regs (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // management serial pins
  input wire logic mdc_i,
  input wire logic mdio_i,
  output logic mdio_o,
  output logic mdio_oe_n_o,
  input wire logic [4:0] phy_addr_i,
  // strap pins
  input wire logic cfg_strap_high_i,
  input wire logic cfg_strap_low_i,
  input wire logic pattern_test_strap_i,
  input wire logic sync_enable_pin_i,
  input wire logic lane_a_loopback_pin_i,
  // control register and lane status
  input wire logic ctrl_loopback_i,
  input wire logic ctrl_power_down_i,
  input wire logic io_std_hstl_i,
  input wire logic comma_detected_i,
  input wire logic [7:0] lane_status_i,
  // global enables
  output logic deskew_en_o,
  output logic sync_sm_en_o,
  output logic inter_packet_gap_en_o,
  output logic prbs_all_en_o,
  output logic comma_all_en_o,
  // lane a controls
  output logic lane_a_ctc_en_o,
  output logic lane_a_multifunction_output_o,
  output logic lane_a_los_en_o,
  output logic lane_a_cfg_high_o,
  output logic lane_a_cfg_low_o,
  output logic lane_a_preemph_bit_high_o,
  output logic lane_a_preemph_bit_low_o,
  output logic lane_a_prbs_en_o,
  output logic lane_a_comma_en_o,
  output logic lane_a_loopback_o,
  output logic lane_a_power_down_o
);
  import xlcr_pkg::*;

  xlcr_mgmt_state_type d;
  xlcr_mgmt_state_type q;
  xlcr_cfg_if cif ();
  logic [15:0] lock;
  logic [15:0] wdata;
  logic [4:0] regad_full;
  logic bit_in;
  logic rise;
  logic wr_glob;
  logic wr_lane;
  logic addr_done;
  logic data_done;

  // bits held by a strap pin
  function automatic logic [15:0] lock_mask(input logic [4:0] s);
    lock_mask = 16'h0000;
    lock_mask[`XLCR_BIT_CFG_HIGH] = s[`XLCR_STRAP_CFG_HIGH];
    lock_mask[`XLCR_BIT_CFG_LOW] = s[`XLCR_STRAP_CFG_LOW];
    lock_mask[`XLCR_BIT_PRBS] = s[`XLCR_STRAP_PRBS];
    lock_mask[`XLCR_BIT_LOOPBACK] = s[`XLCR_STRAP_LPBK];
  endfunction

  // read view of one register
  function automatic logic [15:0] read_view(input logic [4:0] a, input logic [15:0] g,
                                            input logic [15:0] l, input logic [15:0] k);
    case (a)
      `XLCR_REG_GLOBAL: begin
        read_view = (g | k) & `XLCR_GLOBAL_WMASK;
      end
      `XLCR_REG_LANE_A: begin
        read_view = (l | k) & `XLCR_LANE_WMASK;
      end
      default: begin
        read_view = 16'h0000;
      end
    endcase
  endfunction

  always_comb begin
    d = q;
    wr_glob = 1'b0;
    wr_lane = 1'b0;
    lock = lock_mask(q.strap_s2);
    bit_in = q.mdio_s2;
    wdata = {q.shift[14:0], bit_in};
    regad_full = {q.regad[3:0], bit_in};
    rise = q.mdc_s2 & ~q.mdc_prev;
    d.mdc_s1 = mdc_i;
    d.mdc_s2 = q.mdc_s1;
    d.mdc_prev = q.mdc_s2;
    d.mdio_s1 = mdio_i;
    d.mdio_s2 = q.mdio_s1;
    d.strap_s1 = {lane_a_loopback_pin_i, sync_enable_pin_i, pattern_test_strap_i,
                  cfg_strap_low_i, cfg_strap_high_i};
    d.strap_s2 = q.strap_s1;
    d.phy_s1 = phy_addr_i;
    d.phy_s2 = q.phy_s1;
    if (rise) begin
      case (q.st)
        ST_IDLE: begin
          if (bit_in) begin
            if (q.cnt != `XLCR_PREAMBLE_LEN) begin
              d.cnt = q.cnt + 6'h01;
            end
          end else if (q.cnt == `XLCR_PREAMBLE_LEN) begin
            d.st = ST_START;
            d.cnt = 6'h00;
          end else begin
            d.cnt = 6'h00;
          end
        end
        ST_START: begin
          d.st = bit_in ? ST_OP : ST_IDLE;
        end
        ST_OP: begin
          d.op = {q.op[0], bit_in};
          d.cnt = q.cnt + 6'h01;
          if (q.cnt == 6'h01) begin
            d.cnt = 6'h00;
            if (d.op == `XLCR_OP_READ || d.op == `XLCR_OP_WRITE) begin
              d.st = ST_PHY;
            end else begin
              d.st = ST_IDLE;
            end
          end
        end
        ST_PHY: begin
          d.phy = {q.phy[3:0], bit_in};
          d.cnt = q.cnt + 6'h01;
          if (q.cnt == 6'h04) begin
            d.cnt = 6'h00;
            d.st = ST_REG;
          end
        end
        ST_REG: begin
          d.regad = regad_full;
          d.cnt = q.cnt + 6'h01;
          if (q.cnt == 6'h04) begin
            d.cnt = 6'h00;
            d.st = (q.phy == q.phy_s2) ? ST_TA : ST_IDLE;
            d.shift = read_view(regad_full, q.glob, q.lane, lock);
          end
        end
        ST_TA: begin
          d.cnt = q.cnt + 6'h01;
          if (q.cnt == 6'h00) begin
            if (q.op == `XLCR_OP_READ) begin
              d.mdio_out = 1'b0;
              d.mdio_oe_n = 1'b0;
            end
          end else begin
            d.cnt = 6'h00;
            if (q.op == `XLCR_OP_READ) begin
              d.mdio_out = q.shift[15];
              d.shift = {q.shift[14:0], 1'b0};
              d.st = ST_RDATA;
            end else begin
              d.st = ST_WDATA;
            end
          end
        end
        ST_WDATA: begin
          d.shift = wdata;
          d.cnt = q.cnt + 6'h01;
          if (q.cnt == 6'h0F) begin
            d.cnt = 6'h00;
            d.st = ST_IDLE;
            case (q.regad)
              `XLCR_REG_GLOBAL: begin
                wr_glob = 1'b1;
                d.glob = (q.glob & ~(`XLCR_GLOBAL_WMASK & ~lock)) |
                         (wdata & `XLCR_GLOBAL_WMASK & ~lock);
                d.lane = (q.lane & ~(`XLCR_COPY_MASK & ~lock)) |
                         (wdata & `XLCR_COPY_MASK & ~lock);
              end
              `XLCR_REG_LANE_A: begin
                wr_lane = 1'b1;
                d.lane = (q.lane & ~(`XLCR_LANE_WMASK & ~lock)) |
                         (wdata & `XLCR_LANE_WMASK & ~lock);
              end
              default: begin
                d.cnt = 6'h00;
              end
            endcase
          end
        end
        ST_RDATA: begin
          d.cnt = q.cnt + 6'h01;
          if (q.cnt == 6'h0F) begin
            d.cnt = 6'h00;
            d.mdio_out = 1'b1;
            d.mdio_oe_n = 1'b1;
            d.st = ST_IDLE;
          end else begin
            d.mdio_out = q.shift[15];
            d.shift = {q.shift[14:0], 1'b0};
          end
        end
        default: begin
          d.st = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      q <= '0;
      q.st <= ST_IDLE;
      q.glob <= `XLCR_GLOBAL_RESET;
      q.lane <= `XLCR_LANE_RESET;
      q.mdio_out <= 1'b1;
      q.mdio_oe_n <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign cif.glob = q.glob;
  assign cif.lane = q.lane;
  assign cif.straps = q.strap_s2;
  assign cif.ctrl_loopback = ctrl_loopback_i;
  assign cif.ctrl_power_down = ctrl_power_down_i;
  assign cif.io_std_hstl = io_std_hstl_i;
  assign cif.comma_detected = comma_detected_i;
  assign cif.lane_status = lane_status_i;

  xlcr_lane_combine u_combine (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .cif(cif.comb)
  );

  assign mdio_o = q.mdio_out;
  assign mdio_oe_n_o = q.mdio_oe_n;
  assign deskew_en_o = cif.eff.deskew;
  assign sync_sm_en_o = cif.eff.sync_sm;
  assign inter_packet_gap_en_o = cif.eff.inter_packet_gap;
  assign prbs_all_en_o = cif.eff.prbs_all;
  assign comma_all_en_o = cif.eff.comma_all;
  assign lane_a_ctc_en_o = cif.eff.ctc_a;
  assign lane_a_multifunction_output_o = cif.eff.mf_a;
  assign lane_a_los_en_o = cif.eff.los_a;
  assign lane_a_cfg_high_o = cif.eff.cfg_high_a;
  assign lane_a_cfg_low_o = cif.eff.cfg_low_a;
  assign lane_a_preemph_bit_high_o = cif.eff.preemph_bit_high_a;
  assign lane_a_preemph_bit_low_o = cif.eff.preemph_bit_low_a;
  assign lane_a_prbs_en_o = cif.eff.prbs_a;
  assign lane_a_comma_en_o = cif.eff.comma_a;
  assign lane_a_loopback_o = cif.eff.loop_a;
  assign lane_a_power_down_o = cif.eff.pwrdn_a;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  global_reserved_a: assert property ((q.glob & ~`XLCR_GLOBAL_WMASK) == 16'h0000)
    else $error("reserved global bit set");
  lane_reserved_a: assert property ((q.lane & 16'hF000) == 16'h0000)
    else $error("reserved lane bit set");
  global_copy_a: assert property (wr_glob |=> q.lane[11:8] == $past(wdata[11:8]))
    else $error("global write not copied to lane");
  assign addr_done = rise && q.st == ST_REG && q.cnt == 6'h04;
  assign data_done = rise && q.st == ST_WDATA && q.cnt == 6'h0F;

  strap_lock_a: assert property (wr_glob && q.strap_s2[`XLCR_STRAP_CFG_HIGH] |=>
    q.glob[`XLCR_BIT_CFG_HIGH] == $past(q.glob[`XLCR_BIT_CFG_HIGH]))
    else $error("locked global bit changed by write");
  lane_loop_lock_a: assert property (wr_lane && q.strap_s2[`XLCR_STRAP_LPBK] |=>
    $stable(q.lane[`XLCR_BIT_LOOPBACK]))
    else $error("locked lane loopback bit changed by write");
  ext_read_zero_a: assert property (addr_done && regad_full == `XLCR_REG_EXT_STATUS |=>
    q.shift == 16'h0000)
    else $error("extended status read not zero");
  drive_window_a: assert property (!q.mdio_oe_n |-> q.st == ST_TA || q.st == ST_RDATA)
    else $error("management pin driven outside read answer");
  glob_prbs_lock_a: assert property (wr_glob && q.strap_s2[`XLCR_STRAP_PRBS] |=>
    $stable(q.glob[`XLCR_BIT_PRBS]))
    else $error("locked global pattern bit written");
  lane_prbs_lock_a: assert property (wr_lane && q.strap_s2[`XLCR_STRAP_PRBS] |=>
    $stable(q.lane[`XLCR_BIT_PRBS]))
    else $error("locked lane pattern bit written");
  cfg_low_lock_a: assert property (wr_glob && q.strap_s2[`XLCR_STRAP_CFG_LOW] |=>
    $stable(q.glob[`XLCR_BIT_CFG_LOW]))
    else $error("locked global config bit written");
  glob_cfg_take_a: assert property (wr_glob && !q.strap_s2[`XLCR_STRAP_CFG_HIGH] |=>
    q.glob[`XLCR_BIT_CFG_HIGH] == $past(wdata[`XLCR_BIT_CFG_HIGH]))
    else $error("free global config bit not written");
  lane_cfg_lock_a: assert property (wr_lane && q.strap_s2[`XLCR_STRAP_CFG_HIGH] |=>
    $stable(q.lane[`XLCR_BIT_CFG_HIGH]))
    else $error("locked lane config bit written");
  loop_write_take_a: assert property (wr_lane && !q.strap_s2[`XLCR_STRAP_LPBK] |=>
    q.lane[`XLCR_BIT_LOOPBACK] == $past(wdata[`XLCR_BIT_LOOPBACK]))
    else $error("free lane loopback bit not written");
  glob_write_take_a: assert property (wr_glob |=>
    q.glob[14:8] == $past(wdata[14:8]))
    else $error("global enable bits not written");
  copy_preemph_a: assert property (wr_glob |=>
    q.lane[5:4] == $past(wdata[5:4]))
    else $error("preemphasis bits not copied");
  copy_skip_a: assert property (wr_glob |=>
    $stable(q.lane[`XLCR_BIT_LOOPBACK]) && $stable(q.lane[`XLCR_BIT_PWRDN]))
    else $error("lane only bits changed by global write");
  lane_write_scope_a: assert property (wr_lane |=>
    $stable(q.glob))
    else $error("lane write changed global");
  glob_read_zero_a: assert property (addr_done && regad_full == `XLCR_REG_GLOBAL |=>
    !q.shift[15] && !q.shift[3])
    else $error("reserved global bit read as one");
  lane_read_zero_a: assert property (addr_done && regad_full == `XLCR_REG_LANE_A |=>
    q.shift[15:12] == 4'h0)
    else $error("reserved lane bits read as one");
  ext_write_drop_a: assert property (data_done && q.regad == `XLCR_REG_EXT_STATUS |=>
    $stable(q.glob) && $stable(q.lane))
    else $error("extended status write changed storage");
  quiet_hold_a: assert property (!rise |=>
    $stable(q.glob) && $stable(q.lane))
    else $error("storage changed without a write");
  addr_miss_a: assert property (addr_done && q.phy != q.phy_s2 |=>
    q.st == ST_IDLE)
    else $error("frame for other device kept");
  bad_op_a: assert property (rise && q.st == ST_OP && q.cnt == 6'h01 && q.op[0] == bit_in |=>
    q.st == ST_IDLE)
    else $error("unknown operation kept");
  frame_end_a: assert property (data_done |=>
    q.st == ST_IDLE && q.cnt == 6'h00)
    else $error("write frame did not end in idle");
  turn_drive_a: assert property (rise && q.st == ST_TA && q.cnt == 6'h00 && q.op == `XLCR_OP_READ |=>
    !q.mdio_oe_n && !q.mdio_out)
    else $error("turnaround zero not driven");
  read_shift_a: assert property (rise && q.st == ST_RDATA && q.cnt != 6'h0F |=>
    q.mdio_out == $past(q.shift[15]))
    else $error("read bit out of order");
  read_release_a: assert property (rise && q.st == ST_RDATA && q.cnt == 6'h0F |=>
    q.mdio_oe_n && q.mdio_out)
    else $error("pin not released after read");
  idle_release_a: assert property (q.st == ST_IDLE |-> q.mdio_oe_n)
    else $error("pin driven while idle");
  preamble_cap_a: assert property (q.cnt <= `XLCR_PREAMBLE_LEN)
    else $error("bit counter past preamble length");
  wr_glob_c: cover property (wr_glob);
  wr_lane_c: cover property (wr_lane);
  read_drive_c: cover property (q.st == ST_RDATA && !q.mdio_oe_n);
  strap_lock_c: cover property (wr_glob && q.strap_s2[`XLCR_STRAP_CFG_HIGH]);
endmodule

//--- xlcr_defines.svh
`ifndef XLCR_DEFINES_SVH
`define XLCR_DEFINES_SVH
// Summary of operation
// - extended status reads all zeros; writes to it are dropped.
// - a global write overwrites the per-lane settings except loopback and power down (lane bits 3, 0).
// - global bit 15 reads zero, writes ignored.
// - global bit 14 enables deskew machine; resets to 0.
// - global bit 13 enables lane synchronization machine; resets to 0.
// - global bit 12 enables inter-packet gap machine; resets to 0.
// - lane clock compensation is lane bit 11 OR global bit 11.
// - multifunction output picks io standard, comma, signal loss or pattern pass.
// - lane a uses status bits 0 and 4; select ORs lane and global.
// - signal loss detection needs lane bit 8 AND global bit 8; default 1.
// - global bits 7,6 writable only while strap low; effective ORs the strap.
// - lane configuration bits 7,6 are lane OR global OR strap values.
// - preemphasis bits 5,4 are lane OR global values.
// - global bit 3 reads zero, writes ignored.
// - pattern test on all lanes is global bit 2 OR strap; strap locks bit.
// - lane a pattern test is lane bit 2 OR global bit 2 OR strap.
// - comma detection on all lanes needs global bit 1 AND sync pin.
// - lane a comma detection needs lane bit 1, global bit 1, sync pin.
// - lane a loopback is lane bit 3 OR pin OR control bit 14; pin locks bit.
// - lane a power down is lane bit 0 OR control bit 11.
// - lane bits 15:12 read zero, writes ignored.
// - forced bits ignore writes and keep their stored value for later.
`define XLCR_REG_EXT_STATUS 5'h0F
`define XLCR_REG_GLOBAL 5'h10
`define XLCR_REG_LANE_A 5'h11
`define XLCR_BIT_DESKEW 14
`define XLCR_BIT_SYNC_SM 13
`define XLCR_BIT_IPG 12
`define XLCR_BIT_CTC 11
`define XLCR_BIT_MF_HI 10
`define XLCR_BIT_MF_LO 9
`define XLCR_BIT_LOS 8
`define XLCR_BIT_CFG_HIGH 7
`define XLCR_BIT_CFG_LOW 6
`define XLCR_BIT_PRE_HIGH 5
`define XLCR_BIT_PRE_LOW 4
`define XLCR_BIT_LOOPBACK 3
`define XLCR_BIT_PRBS 2
`define XLCR_BIT_COMMA 1
`define XLCR_BIT_PWRDN 0
`define XLCR_STAT_LOS_A 0
`define XLCR_STAT_PRBS_A 4
`define XLCR_GLOBAL_RESET 16'h0102
`define XLCR_LANE_RESET 16'h0102
`define XLCR_GLOBAL_WMASK 16'h7FF6
`define XLCR_LANE_WMASK 16'h0FFF
`define XLCR_COPY_MASK 16'h0FF6
`define XLCR_STRAP_CFG_HIGH 0
`define XLCR_STRAP_CFG_LOW 1
`define XLCR_STRAP_PRBS 2
`define XLCR_STRAP_SYNC 3
`define XLCR_STRAP_LPBK 4
`define XLCR_PREAMBLE_LEN 6'h20
`define XLCR_OP_READ 2'h2
`define XLCR_OP_WRITE 2'h1
`endif

//--- xlcr_pkg.sv
package xlcr_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_START = 3'b001,
    ST_OP = 3'b010,
    ST_PHY = 3'b011,
    ST_REG = 3'b100,
    ST_TA = 3'b101,
    ST_WDATA = 3'b110,
    ST_RDATA = 3'b111
  } xlcr_mdio_state_type;

  typedef struct packed {
    logic deskew;
    logic sync_sm;
    logic inter_packet_gap;
    logic ctc_a;
    logic mf_a;
    logic los_a;
    logic cfg_high_a;
    logic cfg_low_a;
    logic preemph_bit_high_a;
    logic preemph_bit_low_a;
    logic prbs_all;
    logic prbs_a;
    logic comma_all;
    logic comma_a;
    logic loop_a;
    logic pwrdn_a;
  } xlcr_eff_type;

  typedef struct packed {
    logic mdc_s1;
    logic mdc_s2;
    logic mdc_prev;
    logic mdio_s1;
    logic mdio_s2;
    logic [4:0] strap_s1;
    logic [4:0] strap_s2;
    logic [4:0] phy_s1;
    logic [4:0] phy_s2;
    xlcr_mdio_state_type st;
    logic [5:0] cnt;
    logic [1:0] op;
    logic [4:0] phy;
    logic [4:0] regad;
    logic [15:0] shift;
    logic [15:0] glob;
    logic [15:0] lane;
    logic mdio_out;
    logic mdio_oe_n;
  } xlcr_mgmt_state_type;
endpackage

//--- xlcr_cfg_if.sv
`timescale 1ns/1ps
interface xlcr_cfg_if;
  import xlcr_pkg::*;
  logic [15:0] glob;
  logic [15:0] lane;
  logic [4:0] straps;
  logic ctrl_loopback;
  logic ctrl_power_down;
  logic io_std_hstl;
  logic comma_detected;
  logic [7:0] lane_status;
  xlcr_eff_type eff;
  modport regs (
    output glob, lane, straps, ctrl_loopback, ctrl_power_down,
    output io_std_hstl, comma_detected, lane_status,
    input eff
  );
  modport comb (
    input glob, lane, straps, ctrl_loopback, ctrl_power_down,
    input io_std_hstl, comma_detected, lane_status,
    output eff
  );
endinterface

//--- xlcr_lane_combine.sv
`timescale 1ns/1ps
`include "xlcr_defines.svh"
module xlcr_lane_combine (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // stored bits in, effective controls out
  xlcr_cfg_if.comb cif
);
  import xlcr_pkg::*;
  xlcr_eff_type d;
  xlcr_eff_type q;
  logic [15:0] g;
  logic [15:0] l;
  logic [4:0] s;
  logic [1:0] sel;

  always_comb begin
    g = cif.glob;
    l = cif.lane;
    s = cif.straps;
    sel = {l[`XLCR_BIT_MF_HI], l[`XLCR_BIT_MF_LO]} | {g[`XLCR_BIT_MF_HI], g[`XLCR_BIT_MF_LO]};
    d = q;
    d.deskew = g[`XLCR_BIT_DESKEW];
    d.sync_sm = g[`XLCR_BIT_SYNC_SM];
    d.inter_packet_gap = g[`XLCR_BIT_IPG];
    d.ctc_a = l[`XLCR_BIT_CTC] | g[`XLCR_BIT_CTC];
    case (sel)
      2'b00: begin
        d.mf_a = cif.io_std_hstl;
      end
      2'b01: begin
        d.mf_a = cif.comma_detected;
      end
      2'b10: begin
        d.mf_a = cif.lane_status[`XLCR_STAT_LOS_A];
      end
      default: begin
        d.mf_a = cif.lane_status[`XLCR_STAT_PRBS_A];
      end
    endcase
    d.los_a = l[`XLCR_BIT_LOS] & g[`XLCR_BIT_LOS];
    d.cfg_high_a = l[`XLCR_BIT_CFG_HIGH] | g[`XLCR_BIT_CFG_HIGH] | s[`XLCR_STRAP_CFG_HIGH];
    d.cfg_low_a = l[`XLCR_BIT_CFG_LOW] | g[`XLCR_BIT_CFG_LOW] | s[`XLCR_STRAP_CFG_LOW];
    d.preemph_bit_high_a = l[`XLCR_BIT_PRE_HIGH] | g[`XLCR_BIT_PRE_HIGH];
    d.preemph_bit_low_a = l[`XLCR_BIT_PRE_LOW] | g[`XLCR_BIT_PRE_LOW];
    d.prbs_all = g[`XLCR_BIT_PRBS] | s[`XLCR_STRAP_PRBS];
    d.prbs_a = l[`XLCR_BIT_PRBS] | g[`XLCR_BIT_PRBS] | s[`XLCR_STRAP_PRBS];
    d.comma_all = g[`XLCR_BIT_COMMA] & s[`XLCR_STRAP_SYNC];
    d.comma_a = l[`XLCR_BIT_COMMA] & g[`XLCR_BIT_COMMA] & s[`XLCR_STRAP_SYNC];
    d.loop_a = l[`XLCR_BIT_LOOPBACK] | s[`XLCR_STRAP_LPBK] | cif.ctrl_loopback;
    d.pwrdn_a = l[`XLCR_BIT_PWRDN] | cif.ctrl_power_down;
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign cif.eff = q;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  los_and_gate_a: assert property (!cif.glob[`XLCR_BIT_LOS] |=> !q.los_a)
    else $error("signal loss enable set while global bit clear");
  mf_loss_pick_a: assert property (sel == 2'b10 |=> q.mf_a == $past(cif.lane_status[`XLCR_STAT_LOS_A]))
    else $error("multifunction output not showing signal loss");
  prbs_strap_force_a: assert property (s[`XLCR_STRAP_PRBS] [*2] |-> q.prbs_all && q.prbs_a)
    else $error("pattern strap high but pattern test off");
  comma_sync_gate_a: assert property (!s[`XLCR_STRAP_SYNC] |=> !q.comma_all && !q.comma_a)
    else $error("comma detection on without sync pin");
  ctc_or_lane_a: assert property ($rose(cif.lane[`XLCR_BIT_CTC]) |=> q.ctc_a)
    else $error("clock compensation not following lane bit");
  pwrdn_ctrl_a: assert property (cif.ctrl_power_down ##1 cif.ctrl_power_down |-> q.pwrdn_a)
    else $error("power down not following control bit");
  loop_or_a: assert property ((cif.ctrl_loopback || s[`XLCR_STRAP_LPBK]) |=> q.loop_a)
    else $error("loopback not asserted");
  deskew_follow_a: assert property (q.deskew == $past(cif.glob[`XLCR_BIT_DESKEW]))
    else $error("deskew enable differs from global bit");
  mf_prbs_c: cover property (sel == 2'b11 ##1 q.mf_a);
endmodule

//--- xlcr_mdio_station.sv
`timescale 1ns/1ps
module xlcr_mdio_station (
  // clock
  input wire logic sys_clk_i,
  // management pins
  output logic mdc_o,
  output logic mdio_o,
  input wire logic dev_mdio_i,
  input wire logic dev_oe_n_i
);
  logic drv_en;
  logic drv_val;
  // shared data line, pulled up when nobody drives
  assign mdio_o = drv_en ? drv_val : (dev_oe_n_i ? 1'b1 : dev_mdio_i);
  initial begin
    mdc_o = 1'b0;
    drv_en = 1'b1;
    drv_val = 1'b1;
  end
  // one mdc period: data set while low, line sampled just before the rise
  task automatic clk_bit(input logic en, input logic b, output logic seen);
    drv_en = en;
    drv_val = b;
    repeat (5) @(negedge sys_clk_i);
    seen = mdio_o;
    mdc_o = 1'b1;
    repeat (5) @(negedge sys_clk_i);
    mdc_o = 1'b0;
  endtask
  // whole frame with fresh preamble
  task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] ra,
                       input logic [15:0] wd, output logic [15:0] rd);
    logic [31:0] hd;
    logic s;
    hd = {2'b01, op, phy, ra, 2'b10, wd};
    rd = 16'h0000;
    for (int i = 0; i < 32; i++) begin
      clk_bit(1'b1, 1'b1, s);
    end
    for (int i = 31; i >= 0; i--) begin
      if (op == 2'h2 && i < 18) begin
        clk_bit(1'b0, 1'b1, s);
        if (i < 16) begin
          rd[i] = s;
        end
      end else begin
        clk_bit(1'b1, hd[i], s);
      end
    end
    drv_en = 1'b1;
    drv_val = 1'b1;
    repeat (10) @(negedge sys_clk_i);
  endtask
endmodule

//--- xlcr_lane_config_regs_tb.sv
`timescale 1ns/1ps
`include "xlcr_defines.svh"
module xlcr_lane_config_regs_tb;
  import xlcr_pkg::*;
  localparam logic [4:0] PHY = 5'h0A;
  logic sys_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [4:0] strap = 5'h00;
  logic ctl_lb = 1'b0;
  logic ctl_pd = 1'b0;
  logic hstl = 1'b0;
  logic comma = 1'b0;
  logic [7:0] lstat = 8'h00;
  logic [15:0] g_st;
  logic [15:0] l_st;
  logic [15:0] rdv;
  logic [31:0] rv;
  integer seed;
  int error_cnt = 0;
  int compares = 0;
  int cyc = 0;
  wire mdc;
  wire mdio;
  wire dev_mdio;
  wire dev_oe_n;
  wire [15:0] outs;

  always #5 sys_clk_i = ~sys_clk_i;

  xlcr_mdio_station xlcr_mdio_station_inst (.sys_clk_i(sys_clk_i), .mdc_o(mdc), .mdio_o(mdio),
    .dev_mdio_i(dev_mdio), .dev_oe_n_i(dev_oe_n));

  xlcr_lane_config_regs xlcr_lane_config_regs_inst (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
    .mdc_i(mdc), .mdio_i(mdio), .mdio_o(dev_mdio), .mdio_oe_n_o(dev_oe_n), .phy_addr_i(PHY),
    .cfg_strap_high_i(strap[`XLCR_STRAP_CFG_HIGH]), .cfg_strap_low_i(strap[`XLCR_STRAP_CFG_LOW]),
    .pattern_test_strap_i(strap[`XLCR_STRAP_PRBS]), .sync_enable_pin_i(strap[`XLCR_STRAP_SYNC]),
    .lane_a_loopback_pin_i(strap[`XLCR_STRAP_LPBK]), .ctrl_loopback_i(ctl_lb),
    .ctrl_power_down_i(ctl_pd), .io_std_hstl_i(hstl), .comma_detected_i(comma),
    .lane_status_i(lstat), .deskew_en_o(outs[15]), .sync_sm_en_o(outs[14]),
    .inter_packet_gap_en_o(outs[13]), .prbs_all_en_o(outs[12]), .comma_all_en_o(outs[11]),
    .lane_a_ctc_en_o(outs[10]), .lane_a_multifunction_output_o(outs[9]), .lane_a_los_en_o(outs[8]),
    .lane_a_cfg_high_o(outs[7]), .lane_a_cfg_low_o(outs[6]), .lane_a_preemph_bit_high_o(outs[5]),
    .lane_a_preemph_bit_low_o(outs[4]), .lane_a_prbs_en_o(outs[3]), .lane_a_comma_en_o(outs[2]),
    .lane_a_loopback_o(outs[1]), .lane_a_power_down_o(outs[0]));

  // bits held by high straps
  function automatic logic [15:0] lock_mask(input logic lane);
    lock_mask = {8'h00, strap[0], strap[1], 2'b00, lane & strap[4], strap[2], 2'b00};
  endfunction

  function automatic logic [15:0] exp_out(input logic [15:0] g, input logic [15:0] l);
    logic [1:0] sel;
    logic mf;
    sel = l[10:9] | g[10:9];
    mf = (sel == 2'b00) ? hstl : (sel == 2'b01) ? comma : (sel == 2'b10) ? lstat[0] : lstat[4];
    exp_out = {g[14], g[13], g[12], g[2] | strap[2], g[1] & strap[3], l[11] | g[11], mf,
      l[8] & g[8], l[7] | g[7] | strap[0], l[6] | g[6] | strap[1], l[5] | g[5], l[4] | g[4],
      l[2] | g[2] | strap[2], l[1] & g[1] & strap[3], l[3] | strap[4] | ctl_lb, l[0] | ctl_pd};
  endfunction

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [4:0] ra, input logic [15:0] d);
    logic [15:0] m;
    xlcr_mdio_station_inst.frame(`XLCR_OP_WRITE, PHY, ra, d, rdv);
    if (ra == `XLCR_REG_GLOBAL) begin
      m = `XLCR_GLOBAL_WMASK & ~lock_mask(1'b0);
      g_st = (g_st & ~m) | (d & m);
      m = `XLCR_COPY_MASK & ~lock_mask(1'b0);
      l_st = (l_st & ~m) | (d & m);
    end else if (ra == `XLCR_REG_LANE_A) begin
      m = `XLCR_LANE_WMASK & ~lock_mask(1'b1);
      l_st = (l_st & ~m) | (d & m);
    end
  endtask

  task automatic rd_chk(input logic [4:0] ra);
    logic [15:0] e;
    e = (ra == `XLCR_REG_GLOBAL) ? (g_st | lock_mask(1'b0)) :
        (ra == `XLCR_REG_LANE_A) ? (l_st | lock_mask(1'b1)) : 16'h0000;
    xlcr_mdio_station_inst.frame(`XLCR_OP_READ, PHY, ra, 16'h0000, rdv);
    check("read data", e, rdv);
  endtask

  task automatic tally_and_finish;
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // hang guard
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 90000) begin
      error_cnt++;
      tally_and_finish;
    end
  end

  initial begin
    seed = 7947;
    repeat (12) @(negedge sys_clk_i);
    check("outputs in reset", 16'h0000, outs);
    rst_n_i = 1'b1;
    repeat (6) @(negedge sys_clk_i);
    g_st = `XLCR_GLOBAL_RESET;
    l_st = `XLCR_LANE_RESET;
    check("outputs after reset", exp_out(g_st, l_st), outs);
    rd_chk(`XLCR_REG_EXT_STATUS);
    rd_chk(`XLCR_REG_GLOBAL);
    rd_chk(`XLCR_REG_LANE_A);
    rd_chk(5'h12);
    wr(`XLCR_REG_EXT_STATUS, 16'hFFFF);
    rd_chk(`XLCR_REG_EXT_STATUS);
    wr(`XLCR_REG_LANE_A, 16'hFFFF);
    wr(`XLCR_REG_GLOBAL, 16'h0000);
    rd_chk(`XLCR_REG_LANE_A);
    wr(`XLCR_REG_GLOBAL, 16'hFFFF);
    rd_chk(`XLCR_REG_GLOBAL);
    rd_chk(`XLCR_REG_LANE_A);
    // wrong device address and unknown opcodes are dropped
    xlcr_mdio_station_inst.frame(`XLCR_OP_WRITE, PHY ^ 5'h01, `XLCR_REG_GLOBAL, 16'h0000, rdv);
    xlcr_mdio_station_inst.frame(2'h0, PHY, `XLCR_REG_GLOBAL, 16'h0000, rdv);
    xlcr_mdio_station_inst.frame(2'h3, PHY, `XLCR_REG_GLOBAL, 16'h0000, rdv);
    rd_chk(`XLCR_REG_GLOBAL);
    for (int n = 0; n < 28; n++) begin
      rv = $random(seed);
      strap = rv[4:0];
      {ctl_lb, ctl_pd, hstl, comma} = rv[8:5];
      lstat = rv[16:9];
      repeat (4) @(negedge sys_clk_i);
      rv = $random(seed);
      case (rv[17:16])
        2'b00: wr(`XLCR_REG_GLOBAL, rv[15:0]);
        2'b01: wr(`XLCR_REG_LANE_A, rv[15:0]);
        2'b10: wr(`XLCR_REG_EXT_STATUS, rv[15:0]);
        default: wr(5'h12, rv[15:0]);
      endcase
      rd_chk(`XLCR_REG_GLOBAL);
      rd_chk(`XLCR_REG_LANE_A);
      check("effective outputs", exp_out(g_st, l_st), outs);
    end
    tally_and_finish;
  end
endmodule
